// *** rtcc_top.sv ***
// real-time counter: control register, 40-bit counter/match and captured readback
`timescale 1ns/100ps
module rtcc_top
  import rtcc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic supply_good,
  input wire logic crystal_clock_in,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wen,
  input wire logic bus_ren,
  output logic [7:0] bus_rdata,
  output logic match_out,
  output logic [1:0] osc_mode_out,
  output logic osc_select_out,
  output logic timer_in_reset
);

  // control register
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic ctrl_rstn;

  // timer reset synchroniser
  logic tmr_rst_raw_n;
  logic [1:0] rst_sync_r;
  logic tmr_rstn;
  logic in_reset_r;

  // crystal edge sampling
  logic xtal_meta_r;
  logic xtal_sync_r;
  logic xtal_prev_r;
  logic xtal_rise;

  // counter, match and capture
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] match_r;
  logic [CNT_W-1:0] match_nxt;
  logic [CNT_W-1:0] cap_r;
  logic [CNT_W-1:0] cap_nxt;
  logic [CNT_W-1:0] mbits;
  logic cnt_eq;
  logic match_out_r;
  logic match_out_nxt;
  logic pre_run;
  logic pre_tick;

  // read path
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // ------------------------------------------------------------
  // control register, cleared only by power-on or supply loss
  // ------------------------------------------------------------
  // combined async clear: supply loss must act without a clock
  assign ctrl_rstn = resetn & supply_good;

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (bus_wen && bus_addr == ADDR_CTRL) begin
      ctrl_nxt = bus_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge ctrl_rstn) begin
    if (!ctrl_rstn) begin
      ctrl_r <= CTRL_RST_VAL;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign osc_mode_out = ctrl_r[BIT_MODE_HI:BIT_MODE_LO];
  assign osc_select_out = ctrl_r[BIT_OSC_OWN];

  // ------------------------------------------------------------
  // timer reset: asserts at once, releases after two clock edges
  // ------------------------------------------------------------
  // control register is not inside this reset, so bit 7 cannot clear itself
  assign tmr_rst_raw_n = ctrl_rstn & ~ctrl_r[BIT_SOFT_RST];

  always_ff @(posedge ref_clk or negedge tmr_rst_raw_n) begin
    if (!tmr_rst_raw_n) begin
      rst_sync_r <= SYNC_RST_VAL;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign tmr_rstn = rst_sync_r[1];

  always_ff @(posedge ref_clk or negedge ctrl_rstn) begin
    if (!ctrl_rstn) begin
      in_reset_r <= 1'b1;
    end else begin
      in_reset_r <= ~rst_sync_r[1];
    end
  end

  assign timer_in_reset = in_reset_r;

  // ------------------------------------------------------------
  // crystal clock sampled as data; needs ref_clk well above 2x crystal
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      xtal_meta_r <= 1'b0;
      xtal_sync_r <= 1'b0;
      xtal_prev_r <= 1'b0;
    end else begin
      xtal_meta_r <= crystal_clock_in;
      xtal_sync_r <= xtal_meta_r;
      xtal_prev_r <= xtal_sync_r;
    end
  end

  assign xtal_rise = xtal_sync_r & ~xtal_prev_r;

  // prescaler runs only with count enable and counter-run both set
  assign pre_run = ctrl_r[BIT_CNT_EN] & ctrl_r[BIT_CNT_RUN];

  rtcc_prescaler u_pre (
    .ref_clk(ref_clk),
    .tmr_rstn(tmr_rstn),
    .run(pre_run),
    .step(xtal_rise),
    .tick(pre_tick)
  );

  // ------------------------------------------------------------
  // match compare
  // ------------------------------------------------------------
  assign mbits = ~(cnt_r ^ match_r);
  assign cnt_eq = &mbits;

  always_comb begin
    match_out_nxt = cnt_eq & ctrl_r[BIT_REG_ON_MATCH];
  end

  // ------------------------------------------------------------
  // counter and match registers
  // ------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    match_nxt = match_r;
    // byte writes; counter writes land only while counter-run is set, a stopped counter is held at zero
    for (int i = 0; i < NBYTES; i++) begin
      if (bus_wen && bus_addr == ADDR_CNT0 + 8'(i)) begin
        cnt_nxt[i*BYTE_W +: BYTE_W] = bus_wdata;
      end
      if (bus_wen && bus_addr == ADDR_MATCH0 + 8'(i)) begin
        match_nxt[i*BYTE_W +: BYTE_W] = bus_wdata;
      end
    end
    if (!ctrl_r[BIT_CNT_RUN]) begin
      cnt_nxt = CNT_RST_VAL;
    end else if (pre_tick) begin
      // zero never self-clears, otherwise a zero match would stall forever
      if (ctrl_r[BIT_CLR_ON_MATCH] && cnt_eq && cnt_r != CNT_RST_VAL) begin
        cnt_nxt = CNT_RST_VAL;
      end else begin
        cnt_nxt = cnt_r + CNT_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge tmr_rstn) begin
    if (!tmr_rstn) begin
      cnt_r <= CNT_RST_VAL;
      match_r <= MATCH_RST_VAL;
      match_out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      match_r <= match_nxt;
      match_out_r <= match_out_nxt;
    end
  end

  assign match_out = match_out_r;

  // ------------------------------------------------------------
  // readback with capture
  // ------------------------------------------------------------
  always_comb begin
    cap_nxt = cap_r;
    rdata_nxt = rdata_r;
    if (bus_ren) begin
      rdata_nxt = UNMAPPED_VAL;
      if (bus_addr == ADDR_CNT0) begin
        cap_nxt = cnt_r;
        rdata_nxt = cnt_r[BYTE_W-1:0];
      end else if (bus_addr == ADDR_MATCH0) begin
        cap_nxt = match_r;
        rdata_nxt = match_r[BYTE_W-1:0];
      end else if (bus_addr == ADDR_CTRL) begin
        rdata_nxt = ctrl_r;
      end
      for (int i = 1; i < NBYTES; i++) begin
        // higher bytes come from the held capture, never live
        if (bus_addr == ADDR_CNT0 + 8'(i) || bus_addr == ADDR_MATCH0 + 8'(i)) begin
          rdata_nxt = cap_r[i*BYTE_W +: BYTE_W];
        end
      end
      for (int i = 0; i < NBYTES; i++) begin
        if (bus_addr == ADDR_MBITS0 + 8'(i)) begin
          rdata_nxt = mbits[i*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge tmr_rstn) begin
    if (!tmr_rstn) begin
      cap_r <= CNT_RST_VAL;
    end else begin
      cap_r <= cap_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= RDATA_RST_VAL;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign bus_rdata = rdata_r;

endmodule // rtcc_top

// *** rtcc_pkg.sv ***
// shared constants for the real-time counter control and readback block
package rtcc_pkg;

  // counter and match geometry
  localparam int CNT_W = 40;
  localparam int NBYTES = 5;
  localparam int BYTE_W = 8;

  // prescaler: divide by 128, first tick on the 64th crystal edge
  localparam int PRE_W = 7;
  localparam logic [PRE_W-1:0] PRE_RST_VAL = 7'h00;
  localparam logic [PRE_W-1:0] PRE_ONE = 7'h01;
  localparam logic [PRE_W-1:0] PRE_TICK_CNT = 7'h3f;

  // byte addresses on the analog configuration bus
  localparam logic [7:0] ADDR_CNT0 = 8'h40;
  localparam logic [7:0] ADDR_MATCH0 = 8'h48;
  localparam logic [7:0] ADDR_MBITS0 = 8'h50;
  localparam logic [7:0] ADDR_CTRL = 8'h58;

  // timer_control_status field positions
  localparam int BIT_SOFT_RST = 7;
  localparam int BIT_CNT_EN = 6;
  localparam int BIT_REG_ON_MATCH = 5;
  localparam int BIT_MODE_HI = 4;
  localparam int BIT_MODE_LO = 3;
  localparam int BIT_CLR_ON_MATCH = 2;
  localparam int BIT_CNT_RUN = 1;
  localparam int BIT_OSC_OWN = 0;

  // reset values, counter step and unmapped read value
  localparam logic [7:0] CTRL_RST_VAL = 8'h00;
  localparam logic [7:0] RDATA_RST_VAL = 8'h00;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST_VAL = 40'h00_0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 40'h00_0000_0001;
  localparam logic [CNT_W-1:0] MATCH_RST_VAL = 40'h00_0000_0000;
  localparam logic [1:0] SYNC_RST_VAL = 2'h0;

endpackage

// *** rtcc_prescaler.sv ***
// divide-by-128 prescaler stepped by sampled crystal edges
`timescale 1ns/100ps
module rtcc_prescaler
  import rtcc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic tmr_rstn,
  input wire logic run,
  input wire logic step,
  output logic tick
);

  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb begin
    pre_nxt = pre_r;
    tick_nxt = 1'b0;
    if (!run) begin
      // held at zero while stopped, restart always takes 64 edges
      pre_nxt = PRE_RST_VAL;
    end else if (step) begin
      pre_nxt = pre_r + PRE_ONE;
      // prescaled clock rises at 63 -> 64, then every 128 edges
      tick_nxt = (pre_r == PRE_TICK_CNT);
    end
  end

  always_ff @(posedge ref_clk or negedge tmr_rstn) begin
    if (!tmr_rstn) begin
      pre_r <= PRE_RST_VAL;
      tick_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule // rtcc_prescaler

// *** rtcc_chk.sv ***
// port assertions for the timer block
`timescale 1ns/100ps
module rtcc_chk (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic supply_good,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wen,
  input wire logic bus_ren,
  input wire logic [7:0] bus_rdata,
  input wire logic match_out,
  input wire logic [1:0] osc_mode_out,
  input wire logic osc_select_out,
  input wire logic timer_in_reset
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire ctrl_wr = bus_wen && bus_addr == 8'h58;
  mode_follow_a: assert property (ctrl_wr |=> osc_mode_out == $past(bus_wdata[4:3]))
    else $error("mode out wrong");
  own_follow_a: assert property (ctrl_wr |=> osc_select_out == $past(bus_wdata[0]))
    else $error("select out wrong");
  match_gate_a: assert property (ctrl_wr && !bus_wdata[5] |-> ##2 !match_out)
    else $error("match not gated");
  ctrl_clear_a: assert property (
    !supply_good |-> {osc_mode_out, osc_select_out} == 3'h0)
    else $error("control not cleared");
  supply_rst_a: assert property (!supply_good |=> timer_in_reset)
    else $error("no timer reset");
  soft_rst_a: assert property (ctrl_wr && bus_wdata[7] |-> ##[1:3] timer_in_reset)
    else $error("soft reset missed");
  rst_release_a: assert property (
    $rose(supply_good) |-> timer_in_reset[*2] ##[1:3] !timer_in_reset)
    else $error("release timing wrong");
  rdata_hold_a: assert property (!bus_ren |=> $stable(bus_rdata))
    else $error("read data moved");
  cover property (match_out);
  cover property (bus_ren && bus_addr == 8'h40);
  cover property ($fell(timer_in_reset));
endmodule // rtcc_chk
bind rtcc_top rtcc_chk i_chk (.ref_clk(ref_clk), .resetn(resetn), .supply_good(supply_good),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wen(bus_wen), .bus_ren(bus_ren),
  .bus_rdata(bus_rdata), .match_out(match_out), .osc_mode_out(osc_mode_out),
  .osc_select_out(osc_select_out), .timer_in_reset(timer_in_reset));

// *** rtcc_xtal_model.sv ***
// crystal source model, idles low while stopped
`timescale 1ns/100ps
module rtcc_xtal_model #(
  parameter int HALF_NS = 155
) (
  input wire logic run,
  output logic xtal
);
  // half period of 31 ref_clk half periods puts every crystal edge on a bus clock edge
  initial xtal = 1'b0;
  always begin
    #HALF_NS;
    xtal = run ? ~xtal : 1'b0;
  end
endmodule // rtcc_xtal_model

// *** rtcc_top_tb_top.sv ***
// testbench for the timer control and readback block
`timescale 1ns/100ps
module rtcc_top_tb_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic supply_good = 1'b1;
  logic run = 1'b0;
  logic xtal;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wen = 1'b0;
  logic bus_ren = 1'b0;
  logic [7:0] bus_rdata;
  logic match_out;
  logic [1:0] osc_mode_out;
  logic osc_select_out;
  logic timer_in_reset;
  int bad_count = 0;
  int check_count = 0;
  always #5 ref_clk = ~ref_clk;
  rtcc_xtal_model i_xtal (.run(run), .xtal(xtal));
  rtcc_top i_dut (.ref_clk(ref_clk), .resetn(resetn), .supply_good(supply_good),
    .crystal_clock_in(xtal), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wen(bus_wen),
    .bus_ren(bus_ren), .bus_rdata(bus_rdata), .match_out(match_out),
    .osc_mode_out(osc_mode_out), .osc_select_out(osc_select_out),
    .timer_in_reset(timer_in_reset));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // waits on crystal rises, then lets the two-flop sync settle
  task automatic xr(int n);
    repeat (n) @(posedge xtal);
    wt(10);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wen <= 1'b1;
    @(posedge ref_clk);
    bus_wen <= 1'b0;
    #1;
  endtask
  task automatic rc(logic [7:0] a, logic [7:0] e);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_ren <= 1'b1;
    @(posedge ref_clk);
    bus_ren <= 1'b0;
    #1;
    chk($sformatf("rdata %h", a), e, bus_rdata);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    wt(60000);
    bad_count++;
    report_and_stop();
  end
  initial begin
    wt(5);
    resetn <= 1'b1;
    wt(3);
    rc(8'h58, 8'h00);
    rc(8'h40, 8'h00);
    rc(8'h60, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(8'h58, 8'(m * 8 + 1));
      chk("mode", 8'(m), 8'(osc_mode_out));
    end
    rc(8'h58, 8'h19);
    $display("test reset done");
    wr(8'h4a, 8'h5a);
    rc(8'h48, 8'h00);
    rc(8'h4a, 8'h5a);
    wr(8'h4a, 8'h00);
    rc(8'h4a, 8'h5a);
    rc(8'h48, 8'h00);
    rc(8'h4a, 8'h00);
    wr(8'h48, 8'h02);
    // counter 0 against match 2: only bit 1 differs
    rc(8'h50, 8'hfd);
    $display("test capture done");
    wr(8'h58, 8'h66);
    @(posedge ref_clk) run <= 1'b1;
    xr(63);
    rc(8'h40, 8'h00);
    xr(1);
    rc(8'h40, 8'h01);
    xr(128);
    rc(8'h40, 8'h02);
    chk("match", 8'h01, 8'(match_out));
    wr(8'h58, 8'h46);
    wt(2);
    #1;
    chk("match", 8'h00, 8'(match_out));
    wr(8'h58, 8'h66);
    xr(128);
    rc(8'h40, 8'h00);
    xr(128);
    rc(8'h40, 8'h01);
    wr(8'h58, 8'h26);
    xr(200);
    rc(8'h40, 8'h01);
    wr(8'h58, 8'h24);
    rc(8'h40, 8'h00);
    $display("test count done");
    wr(8'h58, 8'h80);
    wt(2);
    #1;
    chk("in_reset", 8'h01, 8'(timer_in_reset));
    rc(8'h58, 8'h80);
    rc(8'h48, 8'h00);
    wr(8'h58, 8'h18);
    @(posedge ref_clk) supply_good <= 1'b0;
    wt(2);
    #1;
    chk("mode", 8'h00, 8'(osc_mode_out));
    rc(8'h58, 8'h00);
    @(posedge ref_clk) supply_good <= 1'b1;
    wt(6);
    #1;
    chk("in_reset", 8'h00, 8'(timer_in_reset));
    $display("test power done");
    report_and_stop();
  end
endmodule // rtcc_top_tb_top
